/* File: rtl/link_channel_cfg.sv */
// Purpose: channel pair enables, sync header kind and resync filtering
// Assumes: register port reads return data one cycle after the strobe
// Notes:   lane and converter scaling and slot mapping driven as outputs
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "link_cfg_params.svh"
module link_channel_cfg
	import link_cfg_pkg::*;
#(
	parameter int FULL_LANES = 8,
	parameter int FULL_CONVS = 8
) (
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic [9:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_write,
	input  wire logic        reg_read,
	output logic      [7:0]  reg_rdata,
	input  wire logic        link_format_is_66b,
	input  wire logic        link_transmit_on,
	input  wire logic        sync_n,
	output logic             ch_a_on,
	output logic             ch_b_on,
	output logic             ch_c_on,
	output logic             ch_d_on,
	output logic      [3:0]  active_lanes,
	output logic      [3:0]  active_convs,
	output logic             pad_tail_bits,
	output logic             upper_in_lower_slots,
	output logic      [1:0]  sync_word_kind,
	output logic      [7:0]  sync_cmd_field,
	output logic             resync_request,
	output logic             sync_error_seen
);
	// Counts must fit the four-bit outputs; converters come in pairs
	if (FULL_LANES < 1 || FULL_LANES > 15 || FULL_CONVS < 2 ||
	    FULL_CONVS > 15 || (FULL_CONVS % 2) != 0) begin : g_bad_counts
		$error("unsupported lane or converter count");
	end

	logic [7:0]    pair_select;
	logic [7:0]    header_reg;
	logic [7:0]    resync_reg;
	logic          one_channel_only;
	logic          upper_pair_on;
	logic          lower_pair_on;
	logic          half_mode;
	logic          sync_level;
	resync_filter_if fi ();

	// Read decode, also used for write targeting
	function automatic logic [1:0] decode(input logic [9:0] a);
		case (a)
			`ADDR_PAIR_SELECT:  decode = 2'h1;
			`ADDR_HEADER_KIND:  decode = 2'h2;
			`ADDR_RESYNC_COUNT: decode = 2'h3;
			default:            decode = 2'h0;
		endcase
	endfunction

	// Channel pair register; reserved bits held at zero [R17]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			pair_select <= `RST_PAIR_SELECT; // [R2] [R3]
		else if (reg_write && decode(reg_addr) == 2'h1)
			pair_select <= {5'h00, reg_wdata[2:0]};
	end

	// Header kind register; written only with link off by software [R16]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			header_reg <= `RST_HEADER_KIND;
		else if (reg_write && decode(reg_addr) == 2'h2)
			header_reg <= {6'h00, reg_wdata[1:0]}; // [R9]
	end

	// Threshold register, five bits used
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			resync_reg <= `RST_RESYNC_COUNT; // [R13]
		else if (reg_write && decode(reg_addr) == 2'h3)
			resync_reg <= {3'h0, reg_wdata[4:0]};
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else if (reg_read) begin
			case (decode(reg_addr))
				2'h1:    reg_rdata <= pair_select;
				2'h2:    reg_rdata <= header_reg;
				2'h3:    reg_rdata <= resync_reg;
				default: reg_rdata <= 8'h00;
			endcase
		end else
			reg_rdata <= 8'h00;
	end

	assign one_channel_only = pair_select[`BIT_ONE_CHANNEL];
	assign upper_pair_on    = pair_select[`BIT_UPPER_PAIR];
	assign lower_pair_on    = pair_select[`BIT_LOWER_PAIR];

	// Channel enables; all-off is undefined and not guarded [R5]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ch_a_on <= 1'b1;
			ch_b_on <= 1'b1;
			ch_c_on <= 1'b1;
			ch_d_on <= 1'b1;
		end else begin
			ch_a_on <= lower_pair_on; // [R3] [R1]
			ch_b_on <= lower_pair_on && !one_channel_only; // [R1]
			ch_c_on <= upper_pair_on && !one_channel_only; // [R2] [R1]
			ch_d_on <= upper_pair_on && !one_channel_only; // [R2]
		end
	end

	assign half_mode = !(lower_pair_on && upper_pair_on);

	// Lane and converter scaling, slot remap and tail padding
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			active_lanes         <= 4'(FULL_LANES);
			active_convs         <= 4'(FULL_CONVS);
			pad_tail_bits        <= 1'b0;
			upper_in_lower_slots <= 1'b0;
		end else begin
			active_lanes  <= half_mode ? 4'((FULL_LANES + 1) / 2)
			                           : 4'(FULL_LANES); // [R6]
			active_convs  <= half_mode ? 4'(FULL_CONVS / 2)
			                           : 4'(FULL_CONVS); // [R6]
			pad_tail_bits <= half_mode && (FULL_LANES % 2 == 1); // [R7]
			upper_in_lower_slots <= !lower_pair_on; // [R8]
		end
	end

	// Header kind only meaningful in 64B/66B formats; reserved gives none
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			sync_word_kind <= hdr_none;
		else if (!link_format_is_66b)
			sync_word_kind <= hdr_none; // [R10]
		else if (header_reg[1:0] == `HDR_CRC12)
			sync_word_kind <= hdr_crc12; // [R9]
		else if (header_reg[1:0] == `HDR_FEC)
			sync_word_kind <= hdr_fec; // [R9]
		else
			sync_word_kind <= hdr_none;
	end

	// No command support: idle headers always [R11]
	assign sync_cmd_field = 8'h00;

	assign fi.threshold = resync_reg[4:0];

	resync_filter u_filter (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.sync_n  (sync_n),
		.fi      (fi)
	);

	// Requests only matter while transmitting
	assign resync_request  = fi.request && link_transmit_on;
	assign sync_error_seen = fi.error_seen;
	assign sync_level      = fi.sync_level;

	// Single-channel mode keeps only channel A running, and A only while the A/B pair bit is set
	a_single_mode: assert property ( // [R1]
		@(posedge mclk) disable iff (sys_rst)
		one_channel_only
		|=> !ch_b_on && !ch_c_on && !ch_d_on)
		else $error("single mode leaves a channel on");

	a_single_keeps_a: assert property ( // [R1]
		@(posedge mclk) disable iff (sys_rst)
		one_channel_only && lower_pair_on
		|=> ch_a_on)
		else $error("channel a lost in single mode");

	// Each pair bit turns its two channels off one cycle later, and on only with single-channel mode off
	a_upper_pair: assert property ( // [R2]
		@(posedge mclk) disable iff (sys_rst)
		!upper_pair_on
		|=> !ch_c_on && !ch_d_on)
		else $error("upper pair not off");

	a_upper_on: assert property ( // [R2]
		@(posedge mclk) disable iff (sys_rst)
		upper_pair_on && !one_channel_only
		|=> ch_c_on && ch_d_on)
		else $error("upper pair not on");

	a_lower_pair: assert property ( // [R3]
		@(posedge mclk) disable iff (sys_rst)
		!lower_pair_on
		|=> !ch_a_on && !ch_b_on)
		else $error("lower pair not off");

	a_lower_on: assert property ( // [R3]
		@(posedge mclk) disable iff (sys_rst)
		lower_pair_on && !one_channel_only
		|=> ch_a_on && ch_b_on)
		else $error("lower pair not on");

	// Half mode halves converters and rounds the lane count up
	a_lane_scale: assert property ( // [R6]
		@(posedge mclk) disable iff (sys_rst)
		half_mode
		|=> active_lanes == 4'((FULL_LANES + 1) / 2))
		else $error("lane count not scaled");

	a_conv_scale: assert property ( // [R6]
		@(posedge mclk) disable iff (sys_rst)
		half_mode
		|=> active_convs == 4'(FULL_CONVS / 2))
		else $error("converter count not scaled");

	a_lane_full: assert property ( // [R6]
		@(posedge mclk) disable iff (sys_rst)
		!half_mode
		|=> active_lanes == 4'(FULL_LANES))
		else $error("lane count not full");

	a_conv_full: assert property ( // [R6]
		@(posedge mclk) disable iff (sys_rst)
		!half_mode
		|=> active_convs == 4'(FULL_CONVS))
		else $error("converter count not full");

	// Tail padding only for an odd lane count in half mode
	a_pad_tail: assert property ( // [R7]
		@(posedge mclk) disable iff (sys_rst)
		half_mode && FULL_LANES % 2 == 1
		|=> pad_tail_bits)
		else $error("tail bits missing");

	a_pad_none: assert property ( // [R7]
		@(posedge mclk) disable iff (sys_rst)
		!half_mode || FULL_LANES % 2 == 0
		|=> !pad_tail_bits)
		else $error("tail bits without need");

	// C and D samples take the A and B slots only with A/B off
	a_slot_remap: assert property ( // [R8]
		@(posedge mclk) disable iff (sys_rst)
		!lower_pair_on
		|=> upper_in_lower_slots)
		else $error("upper samples not moved");

	a_slot_keep: assert property ( // [R8]
		@(posedge mclk) disable iff (sys_rst)
		lower_pair_on
		|=> !upper_in_lower_slots)
		else $error("upper samples moved needlessly");

	// Header kind follows the code only in 64B/66B formats
	a_header_gate: assert property ( // [R10]
		@(posedge mclk) disable iff (sys_rst)
		!link_format_is_66b
		|=> sync_word_kind == hdr_none)
		else $error("header kind outside 66b mode");

	// Reset term: the kind register still shows none at the release edge
	a_crc_kind: assert property ( // [R9]
		@(posedge mclk) disable iff (sys_rst)
		!sys_rst && link_format_is_66b && header_reg[1:0] == `HDR_CRC12
		|=> sync_word_kind == hdr_crc12)
		else $error("crc not selected");

	a_fec_kind: assert property ( // [R9]
		@(posedge mclk) disable iff (sys_rst)
		link_format_is_66b && header_reg[1:0] == 2'h2
		|=> sync_word_kind == hdr_fec)
		else $error("fec not selected");

	a_reserved_kind: assert property ( // [R9]
		@(posedge mclk) disable iff (sys_rst)
		link_format_is_66b && header_reg[0]
		|=> sync_word_kind == hdr_none)
		else $error("reserved code sends a header");

	a_cmd_idle: assert property ( // [R11]
		@(posedge mclk) disable iff (sys_rst)
		1'b1
		|-> sync_cmd_field == 8'h00)
		else $error("command field not idle");

	// Writes land one cycle later with reserved bits forced to zero
	a_pair_write: assert property ( // [R17]
		@(posedge mclk) disable iff (sys_rst)
		reg_write && reg_addr == `ADDR_PAIR_SELECT
		|=> pair_select == {5'h00, $past(reg_wdata[2:0])})
		else $error("pair register write lost");

	a_header_write: assert property ( // [R9]
		@(posedge mclk) disable iff (sys_rst)
		reg_write && reg_addr == `ADDR_HEADER_KIND
		|=> header_reg == {6'h00, $past(reg_wdata[1:0])})
		else $error("header register write lost");

	a_count_write: assert property ( // [R13]
		@(posedge mclk) disable iff (sys_rst)
		reg_write && reg_addr == `ADDR_RESYNC_COUNT
		|=> resync_reg == {3'h0, $past(reg_wdata[4:0])})
		else $error("threshold register write lost");

	a_reserved_zero: assert property ( // [R17]
		@(posedge mclk) disable iff (sys_rst)
		1'b1
		|-> pair_select[7:3] == 5'h00 && header_reg[7:2] == 6'h00 &&
		resync_reg[7:5] == 3'h0)
		else $error("reserved bit set");

	// Read data stand in the cycle after the strobe
	a_read_pair: assert property ( // [R2]
		@(posedge mclk) disable iff (sys_rst)
		reg_read && reg_addr == `ADDR_PAIR_SELECT
		|=> reg_rdata == $past(pair_select))
		else $error("pair register read wrong");

	a_read_header: assert property ( // [R9]
		@(posedge mclk) disable iff (sys_rst)
		reg_read && reg_addr == `ADDR_HEADER_KIND
		|=> reg_rdata == $past(header_reg))
		else $error("header register read wrong");

	a_read_count: assert property ( // [R13]
		@(posedge mclk) disable iff (sys_rst)
		reg_read && reg_addr == `ADDR_RESYNC_COUNT
		|=> reg_rdata == $past(resync_reg))
		else $error("threshold register read wrong");

	// The sync level is taken on every edge, requests only after a low
	a_sync_sample: assert property ( // [R12]
		@(posedge mclk) disable iff (sys_rst)
		1'b1
		|=> sync_level == $past(sync_n))
		else $error("sync not sampled");

	a_req_on_low: assert property ( // [R13]
		@(posedge mclk) disable iff (sys_rst)
		fi.request
		|-> !$past(sync_n))
		else $error("request without a low sample");

	c_half: cover property (@(posedge mclk) disable iff (sys_rst) half_mode);
	c_single: cover property (@(posedge mclk) disable iff (sys_rst)
		one_channel_only);
	c_resync: cover property (@(posedge mclk) disable iff (sys_rst)
		resync_request);
endmodule // link_channel_cfg

/* File: rtl/link_cfg_params.svh */
// Purpose: constants for the channel pair, sync header and resync config
// Assumes: register port with 10-bit byte offsets, 8-bit data
// Notes:   offsets are kept as printed; the channel register offset is ours
// Overview of operation
// (R1) Single-channel bit set runs only channel A; software keeps A/B on.
// (R2) C/D pair bit turns channels C and D on, resets to one.
// (R3) A/B pair bit turns channels A and B on, resets to one.
// (R4) Software clears calibration and link enable before changing pairs.
// (R5) Software never clears every channel enable to power down.
// (R6) One pair off gives lanes ceil(full/2) and converters full/2.
// (R7) Odd full lane count with one pair off pads the highest lane.
// (R8) A/B off moves C and D samples into the A and B frame slots.
// (R9) Two-bit header kind: 0 sends CRC-12, 2 sends FEC, 1 and 3 reserved.
// (R10) Header kind acts only when the link format is a 64B/66B mode.
// (R11) All command fields of the sync word are sent as zero.
// (R12) The active-low sync input is sampled every link clock cycle.
// (R13) A request needs threshold plus one consecutive low samples.
// (R14) Shorter low pulses are error reports and are ignored.
// (R15) Receiver should not report errors; threshold zero is fastest.
// (R16) Header kind and threshold change only with the link disabled.
// (R17) Software writes zero into every reserved bit.
`ifndef LINK_CFG_PARAMS_SVH
`define LINK_CFG_PARAMS_SVH
`define ADDR_PAIR_SELECT   10'h209
`define ADDR_HEADER_KIND   10'h20F
`define ADDR_RESYNC_COUNT  10'h210
`define RST_PAIR_SELECT    8'h03
`define RST_HEADER_KIND    8'h00
`define RST_RESYNC_COUNT   8'h03
`define BIT_LOWER_PAIR     0
`define BIT_UPPER_PAIR     1
`define BIT_ONE_CHANNEL    2
`define HDR_CRC12          2'h0
`define HDR_FEC            2'h2
`endif

/* File: rtl/link_cfg_pkg.sv */
// Purpose: types shared by the link configuration block
// Assumes: nothing beyond the params header
// Notes:   header kinds as sent on the sync word
package link_cfg_pkg;
	typedef enum logic [1:0] {
		hdr_crc12,
		hdr_fec,
		hdr_none
	} sync_word_kind_t;
	typedef enum logic [1:0] {
		watch_idle,
		watch_low,
		watch_held
	} resync_state_t;
endpackage

/* File: rtl/resync_filter_if.sv */
// Purpose: carries threshold and request between control and filter
// Assumes: single clock domain
// Notes:   request is a one-cycle pulse
`timescale 1ns/100ps
interface resync_filter_if;
	logic [4:0] threshold;
	logic       request;
	logic       error_seen;
	logic       sync_level;
	modport ctrl (output threshold, input request, error_seen, sync_level);
	modport filt (input threshold, output request, error_seen, sync_level);
endinterface

/* File: rtl/resync_filter.sv */
// Purpose: filters the active-low sync input into resync requests
// Assumes: sync_n synchronous to mclk, which stands in for the link clock
// Notes:   one request per low run; error pulses only flagged
`timescale 1ns/100ps
module resync_filter
	import link_cfg_pkg::*;
(
	input  wire logic          mclk,
	input  wire logic          sys_rst,
	input  wire logic          sync_n,
	resync_filter_if.filt      fi
);
	logic [5:0]    low_run;
	resync_state_t state;
	logic          req_q;
	logic          err_q;
	logic          lvl_q;

	// Count consecutive low samples, every cycle [R12]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			low_run <= 6'h00;
		else if (sync_n)
			low_run <= 6'h00;
		else if (low_run != 6'h3F)
			low_run <= low_run + 6'h01;
	end

	// Request fires once when run reaches threshold plus one [R13]
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= watch_idle;
			req_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			req_q <= 1'b0;
			err_q <= 1'b0;
			case (state)
				watch_idle: begin
					if (!sync_n) begin
						if (fi.threshold == 5'h00) begin
							req_q <= 1'b1; // [R13]
							state <= watch_held;
						end else
							state <= watch_low;
					end
				end
				watch_low: begin
					if (sync_n) begin
						err_q <= 1'b1; // Short pulse dropped [R14]
						state <= watch_idle;
					end else if (low_run == {1'b0, fi.threshold}) begin
						req_q <= 1'b1; // [R13]
						state <= watch_held;
					end
				end
				watch_held: begin
					if (sync_n)
						state <= watch_idle;
				end
				default: state <= watch_idle;
			endcase
		end
	end

	// Sampled level, 1 while deasserted
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst)
			lvl_q <= 1'b1;
		else
			lvl_q <= sync_n;
	end

	assign fi.request    = req_q;
	assign fi.error_seen = err_q;
	assign fi.sync_level = lvl_q;

	// Request exactly after threshold plus one lows
	a_req_after_run: assert property ( // [R13]
		@(posedge mclk) disable iff (sys_rst)
		$rose(req_q) |-> low_run == {1'b0, fi.threshold} + 6'h01)
		else $error("request without full low run");
	// Error only for a run that ended at or below the threshold
	a_err_short_run: assert property ( // [R14]
		@(posedge mclk) disable iff (sys_rst)
		err_q |-> $past(low_run) != 6'h00 &&
		$past(low_run) <= {1'b0, fi.threshold})
		else $error("error flagged on a full low run");
	a_req_once: assert property ( // [R13]
		@(posedge mclk) disable iff (sys_rst)
		req_q |=> !req_q)
		else $error("request longer than one cycle");
	c_request: cover property (@(posedge mclk) disable iff (sys_rst) req_q);
	c_error: cover property (@(posedge mclk) disable iff (sys_rst) err_q);
endmodule // resync_filter

/* File: tb/sync_receiver_model.sv */
// Purpose: far-end receiver that drives the active-low sync request
// Assumes: sync line synchronous to mclk, idle high between requests
// Notes:   error reporting is a short low run, requests a long one
`timescale 1ns/100ps
module sync_receiver_model (
	input  wire logic mclk,
	output logic      sync_n
);
	// Idle high so no request is pending out of reset
	initial begin
		sync_n = 1'b1;
	end

	// Hold low for exactly n sampling edges, then release
	task automatic low_run(input int n);
		@(posedge mclk);
		sync_n <= 1'b0;
		repeat (n) @(posedge mclk);
		sync_n <= 1'b1;
		repeat (6) @(posedge mclk);
	endtask
endmodule // sync_receiver_model

/* File: tb/serial_link_channel_sync_cfg_tb_top.sv */
// Purpose: self-checking bench for channel pairs, header kind and resync
// Assumes: odd full lane count to exercise tail padding
// Notes:   pulse outputs are counted every cycle rather than sampled once
`timescale 1ns/100ps
`include "link_cfg_params.svh"
module serial_link_channel_sync_cfg_tb_top
	import link_cfg_pkg::*;
;
	logic       mclk, sys_rst, reg_write, reg_read, fmt66, tx_on, sync_n;
	logic [9:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, cmd, got;
	logic       ca, cb, cc, cd, pad, remap, req, err;
	logic [3:0] lanes, convs;
	logic [1:0] kind;
	int         mismatches, samples_checked;
	int         n_req = 0;
	int         n_err = 0;

	link_channel_cfg #(.FULL_LANES(7), .FULL_CONVS(8)) link_channel_cfg_i (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .link_format_is_66b(fmt66),
		.link_transmit_on(tx_on), .sync_n(sync_n), .ch_a_on(ca),
		.ch_b_on(cb), .ch_c_on(cc), .ch_d_on(cd), .active_lanes(lanes),
		.active_convs(convs), .pad_tail_bits(pad),
		.upper_in_lower_slots(remap), .sync_word_kind(kind),
		.sync_cmd_field(cmd), .resync_request(req),
		.sync_error_seen(err));
	sync_receiver_model sync_receiver_model_i (.mclk(mclk), .sync_n(sync_n));

	// Clock at 5 ns period
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Pulses last one cycle, so count them at every edge
	always @(posedge mclk) begin
		if (req === 1'b1) n_req <= n_req + 1;
		if (err === 1'b1) n_err <= n_err + 1;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
		@(posedge mclk);
		reg_write <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [9:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a; reg_read <= 1'b1;
		@(posedge mclk);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic close_out;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic t_reset;
		rd(`ADDR_PAIR_SELECT, got);  chk(got, 8'h03);
		rd(`ADDR_HEADER_KIND, got);  chk(got, 8'h00);
		rd(`ADDR_RESYNC_COUNT, got); chk(got, 8'h03);
		rd(10'h3FF, got);            chk(got, 8'h00);
		chk({4'h0, ca, cb, cc, cd}, 8'h0F);
		chk({lanes, convs}, 8'h78);
		$display("test reset done");
	endtask

	// Link held off while pairs change, as software must
	task automatic pair(input logic [7:0] v, input logic [7:0] fl,
		input logic [7:0] cnt);
		tx_on <= 1'b0;
		wr(`ADDR_PAIR_SELECT, v);
		chk({ca, cb, cc, cd, pad, remap, 2'b00}, fl);
		chk({lanes, convs}, cnt);
	endtask

	task automatic t_pairs;
		pair(8'h01, 8'hC8, 8'h44);
		pair(8'h02, 8'h3C, 8'h44);
		pair(8'h05, 8'h88, 8'h44);
		pair(8'h03, 8'hF0, 8'h78);
		$display("test pairs done");
	endtask

	task automatic kind_is(input logic f, input logic [7:0] v,
		input sync_word_kind_t k);
		fmt66 <= f;
		wr(`ADDR_HEADER_KIND, v);
		chk({6'h00, kind}, {6'h00, k});
		chk(cmd, 8'h00);
	endtask

	task automatic t_kind;
		kind_is(1'b1, 8'h00, hdr_crc12);
		kind_is(1'b1, 8'h02, hdr_fec);
		kind_is(1'b1, 8'h01, hdr_none);
		kind_is(1'b1, 8'h03, hdr_none);
		kind_is(1'b0, 8'h02, hdr_none);
		$display("test header kind done");
	endtask

	// Counters keep running; only the growth over this run is judged
	task automatic run_low(input int n, input int er, input int ee);
		int r0;
		int e0;
		r0 = n_req;
		e0 = n_err;
		sync_receiver_model_i.low_run(n);
		chk(8'(n_req - r0), er[7:0]);
		chk(8'(n_err - e0), ee[7:0]);
	endtask

	task automatic t_resync;
		tx_on <= 1'b1;
		run_low(3, 0, 1);
		run_low(4, 1, 0);
		run_low(9, 1, 0);
		tx_on <= 1'b0;
		wr(`ADDR_RESYNC_COUNT, 8'h00);
		tx_on <= 1'b1;
		run_low(1, 1, 0);
		tx_on <= 1'b0;
		run_low(5, 0, 0);
		$display("test resync done");
	endtask

	// Watchdog cuts a hang short
	initial begin
		#100000;
		mismatches++;
		close_out();
	end

	initial begin
		mismatches = 0; samples_checked = 0;
		sys_rst = 1'b1; reg_write = 1'b0; reg_read = 1'b0;
		reg_addr = 10'h000; reg_wdata = 8'h00; fmt66 = 1'b1; tx_on = 1'b0;
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		t_reset();
		t_pairs();
		t_kind();
		t_resync();
		close_out();
	end
endmodule // serial_link_channel_sync_cfg_tb_top
